//--- inc/sfp_regs.vh
// constants for the multi-lane serial flash pin front end
// assumes inclusion by bare name from design files
`ifndef SFP_REGS_VH
`define SFP_REGS_VH
// lane width codes for one phase
`define SFP_W_SINGLE   2'h0
`define SFP_W_DUAL     2'h1
`define SFP_W_QUAD     2'h2
// erase granularity codes
`define SFP_ER_SECTOR  2'h0
`define SFP_ER_HALF    2'h1
`define SFP_ER_BLOCK   2'h2
`define SFP_ER_CHIP    2'h3
// address bits below each erase unit (4K, 32K, 64K)
`define SFP_SECTOR_AW  12
`define SFP_HALF_AW    15
`define SFP_BLOCK_AW   16
// smallest wrap window in bytes, doubled per wrap code step
`define SFP_WRAP_MIN   24'h000008
`define SFP_PAGE_BYTES 9'h100
`define SFP_SECREG_NUM 3
`define SFP_SECREG_AW  10
// reset pulse time and clock period, both in ns
`define SFP_TRESET_NS  1000
`define SFP_MCLK_NS    8
// reset values of synchronised pins and protect fields
`define SFP_PIN_RST    6'h00
`define SFP_PROT_RST   7'h00
`endif

//--- design/sfp_fifo.v
// small fifo with valid/ready on both ends and a registered output word
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sfp_fifo #(
    parameter W     = 9,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire         mclk,      // clock
    input  wire         rst,       // async reset, high
    input  wire [W-1:0] in_data,   // word to store
    input  wire         in_valid,  // word offered
    output wire         in_ready,  // room for a word
    output reg  [W-1:0] out_data,  // head word
    output reg          out_valid, // head word present
    input  wire         out_ready  // consumer takes head
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wptr_q;
    reg [AW-1:0] rptr_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign push     = in_valid & in_ready;
    // refill the output register whenever it is empty or being taken
    assign pop      = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

    always @(posedge mclk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wptr_q    <= {AW{1'b0}};
            rptr_q    <= {AW{1'b0}};
            cnt_q     <= {(AW+1){1'b0}};
            out_data  <= {W{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q    <= rptr_q + 1'b1;
                out_data  <= mem[rptr_q];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- design/sfp_core.v
// pin front end of a multi-lane serial nor flash: framing, lanes, hold,
// reset pin, write-protect gating, byte assembly and address helpers
// assumes sclk, cs_n and lanes come from pins; command decode sits outside
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.vh"
module sfp_core #(
    parameter         RESET_CYC = (`SFP_TRESET_NS + `SFP_MCLK_NS - 1)
                                  / `SFP_MCLK_NS,
    parameter [127:0] UNIQUE_ID = 128'h0123456789abcdef0f1e2d3c4b5a6978
    // unique id default is arbitrary
) (
    input  wire        mclk,              // 125 MHz clock
    input  wire        rst,               // async reset, high
    input  wire        sclk,              // serial clock pin
    input  wire        cs_n,              // chip select pin, low
    input  wire        lane_zero_i,       // lane 0 in (serial_in_line)
    output wire        lane_zero_o,       // lane 0 out
    output wire        lane_zero_oe,      // lane 0 driven
    input  wire        lane_one_i,        // lane 1 in
    output wire        lane_one_o,        // lane 1 out (single output)
    output wire        lane_one_oe,       // lane 1 driven
    input  wire        lane_two_i,        // lane 2 in / write-protect, low
    output wire        lane_two_o,        // lane 2 out
    output wire        lane_two_oe,       // lane 2 driven
    input  wire        lane_three_i,      // lane 3 in / hold or reset, low
    output wire        lane_three_o,      // lane 3 out
    output wire        lane_three_oe,     // lane 3 driven
    input  wire        quad_enable_bit,   // quad lanes enabled
    input  wire        pause_or_reset_select, // 1: lane 3 is reset pin
    input  wire        status_lock_mode,  // write-protect pin honoured
    input  wire        four_wire_instruction_mode, // instruction on 4 lanes
    input  wire        cont_read_mode,    // frames start with address
    input  wire        dtr_mode,          // both-edge transfer
    input  wire [1:0]  xfer_width,        // lane width after instruction
    input  wire        out_phase,         // device drives lanes now
    input  wire        prog_mode,         // frame carries program data
    output reg  [8:0]  rx_data,           // {instruction flag, byte}
    output reg         rx_valid,          // rx_data present
    input  wire        rx_ready,          // user takes rx_data
    output reg         rx_overrun,        // byte lost, fifo full
    input  wire [7:0]  tx_data,           // next byte to send
    input  wire        tx_valid,          // tx_data offered
    output wire        tx_ready,          // tx_data taken this cycle
    input  wire        addr_load,         // load read address
    input  wire [23:0] addr_in,           // start read address
    input  wire        wrap_enable,       // burst wrap on
    input  wire [1:0]  wrap_len,          // 0..3: 8,16,32,64 bytes
    output reg  [23:0] rd_addr,           // current read address
    input  wire [1:0]  erase_kind,        // erase unit code
    input  wire [23:0] erase_addr,        // any address in unit
    output reg  [23:0] erase_base,        // first address of unit
    input  wire [3:0]  uid_index,         // unique id byte index
    output reg  [7:0]  uid_byte,          // unique id byte
    input  wire [2:0]  secreg_lock,       // otp lock bits 3..1
    input  wire [23:0] secreg_addr,       // security register address
    output reg         secreg_write_ok,   // program/erase allowed
    input  wire        sr_wr_req,         // status write request
    input  wire [6:0]  sr_wr_data,        // new protect fields
    output reg  [6:0]  protect_fields,    // {cmp,sect,tbs,b2,b1,b0,rsv}
    output wire        sr_write_ok,       // status write allowed
    output reg         prog_overflow,     // data past one page dropped
    output reg         frame_active,      // selected and armed
    output reg         hw_reset           // reset pin fired, one pulse
);
    localparam RCW = 12;

    // 2-flop synchronisers: {cs_n, sclk, lane3..lane0}
    reg  [5:0]     pin_s1_q;
    reg  [5:0]     pin_s2_q;
    reg            sclk_p_q, cs_p_q, armed_q, first_q, rst_done_q;
    reg  [7:0]     in_sh_q, out_sh_q, in_sh_d;
    reg  [3:0]     in_cnt_q, out_cnt_q, lane_o_q, in_bits, lane_mask;
    reg  [8:0]     pbytes_q;
    reg  [RCW-1:0] rst_cnt_q;
    reg  [2:0]     w_in, w_out;
    wire           cs_s, sclk_s, rise, fall, selected, dual_std;
    wire           hold_en, hold_act, resetpin_en, in_ev, out_ev;
    wire           byte_done, keep_byte, push, fifo_in_ready, fifo_valid;
    wire [3:0]     lane_s, in_cnt_d;
    wire [1:0]     eff_w, phase_w;
    wire [8:0]     fifo_out;
    wire [7:0]     load_byte, out_src;

    // lanes moved per edge for a width code
    function [2:0] sfp_lanes;
        input [1:0] w;
        begin
            case (w)
                `SFP_W_DUAL: sfp_lanes = 3'h2;
                `SFP_W_QUAD: sfp_lanes = 3'h4;
                default:     sfp_lanes = 3'h1;
            endcase
        end
    endfunction

    // next burst address, wrapping inside an aligned window
    function [23:0] sfp_next_addr;
        input [23:0] a;
        input        en;
        input [1:0]  len;
        reg   [23:0] m;
        begin
            m = (`SFP_WRAP_MIN << len) - 24'h000001;
            if (en) begin
                sfp_next_addr = (a & ~m) | ((a + 24'h000001) & m);
            end else begin
                sfp_next_addr = a + 24'h000001;
            end
        end
    endfunction

    assign cs_s   = pin_s2_q[5];
    assign sclk_s = pin_s2_q[4];
    assign lane_s = pin_s2_q[3:0];
    assign rise   = sclk_s & ~sclk_p_q;
    assign fall   = ~sclk_s & sclk_p_q;

    // pins keep their side functions only outside quad and four-wire use
    assign dual_std    = ~quad_enable_bit
                         & ~four_wire_instruction_mode;
    assign hold_en     = dual_std & ~pause_or_reset_select;
    assign resetpin_en = dual_std & pause_or_reset_select;
    assign selected    = armed_q & ~cs_s;
    assign hold_act    = hold_en & ~lane_s[3] & ~cs_s;

    // ddr moves data on both edges; single rate in on rise, out on fall
    assign in_ev  = selected & ~hold_act & (rise | (dtr_mode & fall));
    assign out_ev = selected & ~hold_act & out_phase
                    & (fall | (dtr_mode & rise));

    // quad widths need the pins freed from protect and hold duty
    assign eff_w = (xfer_width == `SFP_W_QUAD && dual_std) ?
                   `SFP_W_DUAL : xfer_width;
    assign phase_w = (first_q & ~cont_read_mode) ?
                     (four_wire_instruction_mode ? `SFP_W_QUAD
                                                 : `SFP_W_SINGLE)
                     : eff_w;

    always @* begin
        w_in    = sfp_lanes(phase_w);
        w_out   = sfp_lanes(eff_w);
        in_bits = lane_s;
        case (phase_w)
            `SFP_W_DUAL: in_sh_d = {in_sh_q[5:0], in_bits[1:0]};
            `SFP_W_QUAD: in_sh_d = {in_sh_q[3:0], in_bits};
            default:     in_sh_d = {in_sh_q[6:0], in_bits[0]};
        endcase
        case (eff_w)
            `SFP_W_DUAL: lane_mask = 4'h3;
            `SFP_W_QUAD: lane_mask = 4'hf;
            default:     lane_mask = 4'h2;
        endcase
    end

    assign in_cnt_d  = in_cnt_q + {1'b0, w_in};
    assign byte_done = in_ev & ~out_phase & (in_cnt_d >= 4'h8);
    // program data beyond one page is discarded, not stored
    assign keep_byte = ~(prog_mode & ~first_q
                         & (pbytes_q >= `SFP_PAGE_BYTES));
    assign push      = byte_done & keep_byte;

    // a new byte is fetched when the previous one is fully shifted
    assign tx_ready  = out_ev & (out_cnt_q == 4'h0);
    assign load_byte = tx_valid ? tx_data : 8'hff;
    assign out_src   = (out_cnt_q == 4'h0) ? load_byte : out_sh_q;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_q   <= `SFP_PIN_RST;
            pin_s2_q   <= `SFP_PIN_RST;
            sclk_p_q   <= 1'b0;
            cs_p_q     <= 1'b0;
            armed_q    <= 1'b0;
            first_q    <= 1'b0;
            in_sh_q    <= 8'h00;
            in_cnt_q   <= 4'h0;
            out_sh_q   <= 8'hff;
            out_cnt_q  <= 4'h0;
            lane_o_q   <= 4'h0;
            pbytes_q   <= 9'h000;
            rst_cnt_q  <= {RCW{1'b0}};
            rst_done_q <= 1'b0;
            hw_reset   <= 1'b0;
            frame_active  <= 1'b0;
            prog_overflow <= 1'b0;
            rx_overrun    <= 1'b0;
        end else begin
            pin_s1_q <= {cs_n, sclk, lane_three_i, lane_two_i,
                         lane_one_i, lane_zero_i};
            pin_s2_q <= pin_s1_q;
            sclk_p_q <= sclk_s;
            cs_p_q   <= cs_s;
            hw_reset <= 1'b0;
            // reset pin: count low time, fire once per low period
            if (resetpin_en & ~lane_s[3]) begin
                if (rst_cnt_q < RESET_CYC[RCW-1:0]) begin
                    rst_cnt_q <= rst_cnt_q + 1'b1;
                end else if (~rst_done_q) begin
                    rst_done_q <= 1'b1;
                    hw_reset   <= 1'b1;
                end
            end else begin
                rst_cnt_q  <= {RCW{1'b0}};
                rst_done_q <= 1'b0;
            end
            // only a seen high-to-low select arms the interface
            if (cs_p_q & ~cs_s) begin
                armed_q <= 1'b1;
                first_q <= 1'b1;
            end
            if (cs_s | rst_done_q) begin
                in_cnt_q  <= 4'h0;
                out_cnt_q <= 4'h0;
                pbytes_q  <= 9'h000;
            end
            if (rst_done_q) begin
                armed_q <= 1'b0;
            end
            frame_active <= selected;
            if (~cs_p_q & cs_s) begin
                prog_overflow <= 1'b0;
                rx_overrun    <= 1'b0;
            end
            if (in_ev & ~out_phase) begin
                in_sh_q  <= in_sh_d;
                in_cnt_q <= byte_done ? 4'h0 : in_cnt_d;
            end
            if (byte_done) begin
                first_q <= 1'b0;
                if (prog_mode & ~first_q & keep_byte) begin
                    pbytes_q <= pbytes_q + 9'h001;
                end
                if (~keep_byte) begin
                    prog_overflow <= 1'b1;
                end
                if (push & ~fifo_in_ready) begin
                    rx_overrun <= 1'b1;
                end
            end
            // output bits change on the driving edge
            if (out_ev) begin
                case (eff_w)
                    `SFP_W_DUAL: begin
                        lane_o_q <= {2'b00, out_src[7:6]};
                        out_sh_q <= {out_src[5:0], 2'b11};
                    end
                    `SFP_W_QUAD: begin
                        lane_o_q <= out_src[7:4];
                        out_sh_q <= {out_src[3:0], 4'hf};
                    end
                    default: begin
                        lane_o_q <= {2'b00, out_src[7], 1'b0};
                        out_sh_q <= {out_src[6:0], 1'b1};
                    end
                endcase
                out_cnt_q <= ((out_cnt_q == 4'h0) ? 4'h8 : out_cnt_q)
                             - {1'b0, w_out};
            end
        end
    end

    // lanes float when deselected, on hold or outside an output phase
    assign lane_zero_o   = lane_o_q[0];
    assign lane_one_o    = lane_o_q[1];
    assign lane_two_o    = lane_o_q[2];
    assign lane_three_o  = lane_o_q[3];
    assign lane_zero_oe  = frame_active & selected & ~hold_act & out_phase
                           & lane_mask[0];
    assign lane_one_oe   = frame_active & selected & ~hold_act & out_phase
                           & lane_mask[1];
    assign lane_two_oe   = frame_active & selected & ~hold_act & out_phase
                           & lane_mask[2];
    assign lane_three_oe = frame_active & selected & ~hold_act & out_phase
                           & lane_mask[3];

    // the source cannot be stalled, so a full fifo shows as overrun
    sfp_fifo #(
        .W     (9),
        .DEPTH (4),
        .AW    (2)
    ) u_rx_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   ({first_q & ~cont_read_mode, in_sh_d}),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (rx_ready | ~rx_valid)
    );

    // status write gate: hardware protect ignored in quad operation
    assign sr_write_ok = ~(status_lock_mode & ~lane_s[2] & dual_std);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_data         <= 9'h000;
            rx_valid        <= 1'b0;
            rd_addr         <= 24'h000000;
            erase_base      <= 24'h000000;
            uid_byte        <= 8'h00;
            secreg_write_ok <= 1'b0;
            protect_fields  <= `SFP_PROT_RST;
        end else begin
            if (rx_ready | ~rx_valid) begin
                rx_data  <= fifo_out;
                rx_valid <= fifo_valid;
            end
            if (addr_load) begin
                rd_addr <= addr_in;
            end else if (tx_ready) begin
                rd_addr <= sfp_next_addr(rd_addr, wrap_enable, wrap_len);
            end
            if (sr_wr_req & sr_write_ok) begin
                protect_fields <= sr_wr_data;
            end
            case (erase_kind)
                `SFP_ER_SECTOR: erase_base <= {erase_addr[23:`SFP_SECTOR_AW],
                                               12'h000};
                `SFP_ER_HALF:   erase_base <= {erase_addr[23:`SFP_HALF_AW],
                                               15'h0000};
                `SFP_ER_BLOCK:  erase_base <= {erase_addr[23:`SFP_BLOCK_AW],
                                               16'h0000};
                default:        erase_base <= 24'h000000;
            endcase
            uid_byte <= UNIQUE_ID[{uid_index, 3'b000} +: 8];
            // registers 1..3 at 4K steps; offsets above 1023 are invalid
            secreg_write_ok <= (secreg_addr[23:14] == 10'h000)
                & (secreg_addr[11:`SFP_SECREG_AW] == 2'h0)
                & (secreg_addr[13:12] != 2'h0)
                & ~secreg_lock[secreg_addr[13:12] - 2'h1];
        end
    end
endmodule
`default_nettype wire

//--- tb/sfp_core_props.sv
// port assertions for the serial flash pin front end
// bound into sfp_core; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sfp_core_chk #(
    parameter [127:0] UNIQUE_ID = 128'h0
) (
    input wire logic         mclk,             // clock
    input wire logic         rst,              // async reset
    input wire logic         cs_n,             // select pin
    input wire logic         lane_zero_oe,     // lane 0 drive
    input wire logic         lane_one_oe,      // lane 1 drive
    input wire logic         lane_two_oe,      // lane 2 drive
    input wire logic         lane_three_oe,    // lane 3 drive
    input wire logic         lane_two_i,       // protect pin
    input wire logic         quad_enable_bit,  // quad lanes
    input wire logic         pause_or_reset_select, // reset pin
    input wire logic         status_lock_mode, // pin honoured
    input wire logic         four_wire_instruction_mode, // 4-lane op
    input wire logic         sr_wr_req,        // status write
    input wire logic [6:0]   sr_wr_data,       // new fields
    input wire logic [6:0]   protect_fields,   // stored fields
    input wire logic         sr_write_ok,      // write allowed
    input wire logic [1:0]   erase_kind,       // erase unit
    input wire logic [23:0]  erase_addr,       // erase address
    input wire logic [23:0]  erase_base,       // unit base
    input wire logic [3:0]   uid_index,        // id byte index
    input wire logic [7:0]   uid_byte,         // id byte
    input wire logic         hw_reset          // reset pulse
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    deselect_float_a: assert property (cs_n [*4] |->
        !(lane_zero_oe | lane_one_oe | lane_two_oe | lane_three_oe))
        else $error("lane driven while deselected");
    wp_block_a: assert property ((status_lock_mode && !lane_two_i
        && !quad_enable_bit && !four_wire_instruction_mode) [*4]
        |-> !sr_write_ok) else $error("status write not blocked");
    quad_wp_off_a: assert property (quad_enable_bit [*2]
        |-> sr_write_ok) else $error("protect pin used in quad");
    sr_update_a: assert property (sr_wr_req && sr_write_ok
        |=> protect_fields == $past(sr_wr_data)) else $error("no update");
    sr_hold_a: assert property (sr_wr_req && !sr_write_ok
        |=> $stable(protect_fields)) else $error("locked fields changed");
    erase_sector_a: assert property (erase_kind == 2'h0 |=>
        erase_base == ($past(erase_addr) & 24'hfff000))
        else $error("sector base wrong");
    uid_pick_a: assert property (1'b1 |=>
        uid_byte == UNIQUE_ID[8*$past(uid_index) +: 8]) else $error("id");
    hw_pulse_a: assert property (hw_reset |->
        pause_or_reset_select ##1 !hw_reset) else $error("reset pulse");
    cover property (sr_wr_req && !sr_write_ok);
    cover property (hw_reset);
    cover property (erase_kind == 2'h1);
endmodule
bind sfp_core sfp_core_chk #(.UNIQUE_ID(UNIQUE_ID)) chk (.*);
`default_nettype wire

//--- tb/sfp_host.sv
// host controller model: framing, serial clock, lane drive
// clock idles low between frames; released lanes flip level
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
    output var logic       sclk, // serial clock
    output var logic       cs_n, // chip select, low
    output var logic [3:0] hd,   // host lane drive
    input wire logic [3:0] w     // resolved lanes
);
    initial begin
        sclk = 0;
        cs_n = 1;
        hd = 4'hc;
    end
    task open;
        cs_n = 0;
        #102;
    endtask
    task close;
        #50 cs_n = 1;
        hd[1:0] = ~hd[1:0];
    endtask
    // 125 ns period, far below the clock ceiling
    task xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            hd[0] = b[i];
            #17.5 sclk = 1;
            #62.5 sclk = 0;
            #45 r = {r[6:0], w[1]};
        end
    endtask
endmodule
`default_nettype wire

//--- tb/test_sfp_core.sv
// self-checking bench for the pin front end
// host model drives the link; bench drives config at falling edge
`timescale 1ns/1ps
`default_nettype none
module test_sfp_core;
    localparam [127:0] UID = 128'h00112233445566778899aabbccddeeff;
    // id value above is arbitrary
    logic mclk = 0, rst = 1, quad_enable_bit = 0, status_lock_mode = 0;
    logic pause_or_reset_select = 0, four_wire_instruction_mode = 0;
    logic cont_read_mode = 0, dtr_mode = 0, out_phase = 0, prog_mode = 0;
    logic rx_ready = 0, tx_valid = 0, addr_load = 0, wrap_enable = 0;
    logic sr_wr_req = 0, rx_valid, rx_overrun, tx_ready, secreg_write_ok;
    logic sr_write_ok, prog_overflow, frame_active, hw_reset;
    logic lane_zero_o, lane_one_o, lane_two_o, lane_three_o, lane_zero_oe;
    logic lane_one_oe, lane_two_oe, lane_three_oe;
    logic [1:0] xfer_width = 0, wrap_len = 0, erase_kind = 0;
    logic [2:0] secreg_lock = 0;
    logic [3:0] uid_index = 0;
    logic [6:0] sr_wr_data = 0, protect_fields, pf = 0;
    logic [7:0] tx_data = 0, uid_byte;
    logic [8:0] rx_data;
    logic [23:0] addr_in = 0, erase_addr = 0, secreg_addr = 0;
    logic [23:0] rd_addr, erase_base;
    int n_errors = 0, total_checks = 0;
    wire sclk, cs_n;
    wire [3:0] hd;
    wire [3:0] oe = {lane_three_oe, lane_two_oe, lane_one_oe, lane_zero_oe};
    wire [3:0] o = {lane_three_o, lane_two_o, lane_one_o, lane_zero_o};
    wire [3:0] w = (oe & o) | (~oe & hd);
    sfp_host host (.sclk(sclk), .cs_n(cs_n), .hd(hd), .w(w));
    sfp_core #(.RESET_CYC(4), .UNIQUE_ID(UID)) DUT (.*,
        .lane_zero_i(w[0]), .lane_one_i(w[1]),
        .lane_two_i(w[2]), .lane_three_i(w[3]));
    always #4 mclk = ~mclk;
    task chk(input logic [31:0] s, e, input string n);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task conclude;
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task take(input logic [8:0] e);
        @(negedge mclk);
        for (int c = 0; c < 50 && rx_valid !== 1'b1; c++) @(negedge mclk);
        chk({rx_valid, rx_data}, {1'b1, e}, "rx word");
        if (rx_valid !== 1'b1) conclude;
        rx_ready <= 1;
        @(negedge mclk) rx_ready <= 0;
    endtask
    task t_hwrst;
        int n;
        n = 0;
        @(negedge mclk) pause_or_reset_select <= 1;
        host.hd[3] <= 0;
        repeat (20) @(negedge mclk) n += hw_reset;
        chk(n, 1, "reset pulses");
        host.hd[3] <= 1;
        @(negedge mclk) pause_or_reset_select <= 0;
    endtask
    task t_fill;
        logic [7:0] r;
        host.open();
        chk(frame_active, 1, "armed");
        for (int k = 0; k < 7; k++) host.xfer(8'ha5 + k, r);
        chk(rx_overrun, 1, "overrun");
        take(9'h1a5);
        take(9'h0a6);
        host.close();
    endtask
    task t_tx;
        logic [7:0] r;
        @(negedge mclk) {out_phase, tx_valid, wrap_enable} <= 3'h7;
        {tx_data, addr_load, addr_in} <= {8'h96, 1'b1, 24'h000007};
        @(negedge mclk) addr_load <= 0;
        host.open();
        host.xfer(8'h00, r);
        chk(r, 8'h96, "serial out");
        chk(rd_addr, 24'h000000, "wrapped addr");
        host.close();
        repeat (12) @(negedge mclk);
        chk(oe, 0, "float");
        {out_phase, tx_valid, wrap_enable} <= 3'h0;
    endtask
    task wp(input logic s, l, q, input logic [6:0] d);
        @(negedge mclk) {status_lock_mode, quad_enable_bit} <= {s, q};
        host.hd[2] <= l;
        repeat (5) @(negedge mclk);
        {sr_wr_req, sr_wr_data} <= {1'b1, d};
        @(negedge mclk) sr_wr_req <= 0;
        if (!(s && !l && !q)) pf = d;
        @(negedge mclk) chk(protect_fields, pf, "protect");
    endtask
    task t_misc;
        for (int k = 0; k < 4; k++) begin
            @(negedge mclk) {erase_kind, erase_addr} <= {k[1:0], 24'habcdef};
            uid_index <= 4'(k * 5);
            @(negedge mclk);
            chk(erase_base, k == 3 ? 0 : 24'habcdef & (k == 0 ? 24'hfff000
                : k == 1 ? 24'hff8000 : 24'hff0000), "erase base");
            chk(uid_byte, UID[k*40 +: 8], "unique id");
        end
        {secreg_addr, secreg_lock} <= {24'h001234, 3'h6};
        @(negedge mclk) secreg_lock <= 3'h1;
        chk(secreg_write_ok, 1, "otp open");
        @(negedge mclk) chk(secreg_write_ok, 0, "otp locked");
    endtask
    // instruction plus one full page, then a held byte, then one too many
    task t_prog;
        logic [7:0] r;
        {prog_mode, rx_ready} <= 2'h3;
        host.open();
        for (int k = 0; k < 257; k++) host.xfer(8'h5a, r);
        host.hd[3] = 0;
        host.xfer(8'h5a, r);
        chk(prog_overflow, 0, "page full, held");
        host.hd[3] = 1;
        host.xfer(8'h5a, r);
        chk(prog_overflow, 1, "page overflow");
        host.close();
        @(negedge mclk) {prog_mode, rx_ready} <= 2'h0;
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst <= 0;
        t_hwrst;
        t_fill;
        t_tx;
        wp(1, 0, 0, 7'h11);
        wp(1, 1, 0, 7'h22);
        wp(1, 0, 1, 7'h33);
        wp(0, 1, 0, 7'h44);
        t_misc;
        t_prog;
        conclude;
    end
endmodule
`default_nettype wire
